// *** hdl/cspp_defines.svh ***
`ifndef CSPP_DEFINES_SVH
`define CSPP_DEFINES_SVH

// ----------------------------------------------------------------
// bus widths
// ----------------------------------------------------------------
`define CSPP_ADDR_W         16
`define CSPP_DATA_W         16

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define CSPP_OFS_RUN_STATE  16'hF405
`define CSPP_OFS_CLEAR      16'hF421
`define CSPP_OFS_MASK       16'hF422
`define CSPP_OFS_FLAG       16'hF427
`define CSPP_OFS_CODE       16'hF428
`define CSPP_OFS_IRQ_STAT   16'hF430
`define CSPP_OFS_IRQ_MASK   16'hF431

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CSPP_CLEAR_BIT      0
`define CSPP_SRC_N          12
`define CSPP_SRC_MSB        11
`define CSPP_RSV_MSB        15
`define CSPP_RSV_LSB        12
`define CSPP_STATE_MSB      2
`define CSPP_EV_N           2
`define CSPP_EV_ERR         0
`define CSPP_EV_STATE       1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CSPP_MASK_RST       12'h003
`define CSPP_CLEAR_RST      1'h0
`define CSPP_CODE_RST       12'h000
`define CSPP_IRQ_MASK_RST   2'h0
`define CSPP_RDATA_RST      16'h0000
`define CSPP_FLAG_RST       1'h0
`define CSPP_EVENT_RST      2'h0
`define CSPP_IRQ_RST        1'h0

`endif

// *** hdl/cspp_pkg.sv ***
`include "cspp_defines.svh"

package cspp_pkg;

    // ----------------------------------------------------------------
    // core run-state codes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CSPP_ST_OFF   = 3'b000,
        CSPP_ST_RUN   = 3'b001,
        CSPP_ST_PAUSE = 3'b010,
        CSPP_ST_SLEEP = 3'b011,
        CSPP_ST_STALL = 3'b100
    } cspp_run_state_t;

    // ----------------------------------------------------------------
    // core condition as seen from the core logic
    // ----------------------------------------------------------------
    typedef struct packed {
        logic active;
        logic paused;
        logic sleeping;
        logic stalled;
    } cspp_core_cond_t;

    // ----------------------------------------------------------------
    // register port request
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [`CSPP_ADDR_W-1:0] addr;
        logic [`CSPP_DATA_W-1:0] wdata;
        logic                    wr;
        logic                    rd;
    } cspp_bus_req_t;

endpackage

// *** hdl/cspp_state_enc.sv ***
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// live run-state encoder
// ----------------------------------------------------------------
module cspp_state_enc
    import cspp_pkg::*;
(
    input  wire cspp_core_cond_t cond,
    output var  cspp_run_state_t code
);

    always_comb begin
        case (1'b1)
            !cond.active: code = CSPP_ST_OFF;
            cond.stalled: code = CSPP_ST_STALL;
            cond.paused:  code = CSPP_ST_PAUSE;
            cond.sleeping: code = CSPP_ST_SLEEP;
            default:      code = CSPP_ST_RUN;
        endcase
    end

endmodule // cspp_state_enc

`default_nettype wire

// *** hdl/cspp_core.sv ***
// Overview of operation
// - run-state field shows the core condition at the moment of the read
// - code 000 means core not running: after boot and after a halt
// - code 001 means core running normally
// - code 010 means paused by a pause instruction, clock gated
// - code 011 means sleeping until the next audio sample
// - code 100 means stalled for a few cycles while requests are serviced
// - rising edge of clear bit 0 clears flag and error state; level does nothing
// - parity errors are reported only from memories whose mask bit is 0
// - mask bits 11..8 gate data memory b banks 3..0, reset 0
// - mask bits 7..4 gate data memory a banks 3..0, reset 0
// - mask bits 3 and 2 gate program memories b and a, reset 0
// - mask bits 1 and 0 gate rate converters b and a, reset 1
// - mask bits 15..12 are reserved and read zero
// - error flag is sticky until the clear edge
// - error code holds the first reported error until cleared
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "cspp_defines.svh"

module cspp_core
    import cspp_pkg::*;
(
    input  wire  logic                    clk_sys,
    input  wire  logic                    srst,
    input  wire  cspp_bus_req_t           bus,
    output logic [`CSPP_DATA_W-1:0]       rd_data,
    input  wire  cspp_core_cond_t         core_cond,
    input  wire  logic [`CSPP_SRC_N-1:0]  parity_err,
    output logic                          error_flag,
    output logic [`CSPP_SRC_N-1:0]        error_code,
    output cspp_run_state_t               run_state,
    output logic                          irq
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    cspp_run_state_t              live_state;
    logic [`CSPP_SRC_N-1:0]       mask;
    logic                         clear_bit;
    logic                         clear_prev;
    logic                         clear_edge;
    logic [`CSPP_SRC_N-1:0]       reported;
    logic                         any_report;
    logic [`CSPP_EV_N-1:0]        irq_stat;
    logic [`CSPP_EV_N-1:0]        irq_mask;
    logic [`CSPP_EV_N-1:0]        ev;
    logic [`CSPP_EV_N-1:0]        next_irq_stat;
    logic [`CSPP_EV_N-1:0]        next_irq_mask;
    logic [`CSPP_DATA_W-1:0]      next_rd_data;
    logic                         wr_clear;
    logic                         wr_mask;
    logic                         wr_irq_stat;
    logic                         wr_irq_mask;

    // ----------------------------------------------------------------
    // run-state encoding
    // ----------------------------------------------------------------
    cspp_state_enc u_enc (
        .cond (core_cond),
        .code (live_state)
    );

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            run_state <= CSPP_ST_OFF;
        end else begin
            run_state <= live_state;
        end
    end

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    assign wr_clear    = bus.wr && (bus.addr == `CSPP_OFS_CLEAR);
    assign wr_mask     = bus.wr && (bus.addr == `CSPP_OFS_MASK);
    assign wr_irq_stat = bus.wr && (bus.addr == `CSPP_OFS_IRQ_STAT);
    assign wr_irq_mask = bus.wr && (bus.addr == `CSPP_OFS_IRQ_MASK);

    // ----------------------------------------------------------------
    // parity mask register
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            mask <= `CSPP_MASK_RST;
        end else if (wr_mask) begin
            mask <= bus.wdata[`CSPP_SRC_MSB:0];
        end
    end

    // ----------------------------------------------------------------
    // clear control and edge detect
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clear_bit <= `CSPP_CLEAR_RST;
        end else if (wr_clear) begin
            clear_bit <= bus.wdata[`CSPP_CLEAR_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            clear_prev <= `CSPP_CLEAR_RST;
        end else begin
            clear_prev <= clear_bit;
        end
    end

    // software must drop the bit again before the next clear can act
    assign clear_edge = clear_bit && !clear_prev;

    // ----------------------------------------------------------------
    // error reporting
    // ----------------------------------------------------------------
    assign reported   = parity_err & ~mask;
    assign any_report = |reported;

    // a report in the clear cycle survives: set wins over clear
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            error_flag <= `CSPP_FLAG_RST;
        end else if (clear_edge) begin
            error_flag <= any_report;
        end else if (any_report) begin
            error_flag <= 1'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            error_code <= `CSPP_CODE_RST;
        end else if (clear_edge) begin
            error_code <= reported;
        end else if (!error_flag && any_report) begin
            error_code <= reported;
        end
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    assign ev[`CSPP_EV_ERR]   = any_report;
    assign ev[`CSPP_EV_STATE] = (live_state != run_state);

    always_comb begin
        next_irq_stat = irq_stat;
        if (wr_irq_stat) begin
            next_irq_stat = irq_stat & ~bus.wdata[`CSPP_EV_N-1:0];
        end
        next_irq_stat = next_irq_stat | ev;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_stat <= `CSPP_EVENT_RST;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_irq_mask) begin
            next_irq_mask = bus.wdata[`CSPP_EV_N-1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq_mask <= `CSPP_IRQ_MASK_RST;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            irq <= `CSPP_IRQ_RST;
        end else begin
            irq <= |(next_irq_stat & next_irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        next_rd_data = `CSPP_RDATA_RST;
        case (bus.addr)
            `CSPP_OFS_RUN_STATE: begin
                next_rd_data[`CSPP_STATE_MSB:0] = live_state;
            end
            `CSPP_OFS_CLEAR: begin
                next_rd_data[`CSPP_CLEAR_BIT] = clear_bit;
            end
            `CSPP_OFS_MASK: begin
                next_rd_data[`CSPP_SRC_MSB:0] = mask;
            end
            `CSPP_OFS_FLAG: begin
                next_rd_data[0] = error_flag;
            end
            `CSPP_OFS_CODE: begin
                next_rd_data[`CSPP_SRC_MSB:0] = error_code;
            end
            `CSPP_OFS_IRQ_STAT: begin
                next_rd_data[`CSPP_EV_N-1:0] = irq_stat;
            end
            `CSPP_OFS_IRQ_MASK: begin
                next_rd_data[`CSPP_EV_N-1:0] = irq_mask;
            end
            default: begin
                next_rd_data = `CSPP_RDATA_RST;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rd_data <= `CSPP_RDATA_RST;
        end else if (bus.rd) begin
            rd_data <= next_rd_data;
        end else begin
            rd_data <= `CSPP_RDATA_RST;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    sequence s_clear_high;
        wr_clear && bus.wdata[`CSPP_CLEAR_BIT];
    endsequence

    sequence s_clear_rise;
        !clear_bit ##0 s_clear_high ##1 clear_edge;
    endsequence

    sequence s_first_error;
        !error_flag && !clear_edge && any_report;
    endsequence

    chk_clear_wipes: assert property (
        s_clear_rise ##0 !any_report |=> !error_flag && (error_code == '0))
    else $error("clear edge did not wipe the error manager");

    chk_level_holds: assert property (
        clear_bit && clear_prev && error_flag |=> error_flag)
    else $error("static clear level cleared the flag");

    chk_flag_sticky: assert property (
        error_flag && !clear_edge |=> error_flag)
    else $error("error flag dropped without a clear edge");

    chk_report_sets: assert property (
        any_report |=> error_flag ##0 (error_code != '0))
    else $error("unmasked error not recorded");

    chk_first_code: assert property (
        error_flag && !clear_edge |=> error_code == $past(error_code))
    else $error("error code changed after the first error");

    chk_masked_quiet: assert property (
        !error_flag && !clear_edge && ((parity_err & ~mask) == '0)
        |=> !error_flag)
    else $error("masked parity error was reported");

    chk_mask_keeps: assert property (
        wr_mask && error_flag && !clear_edge
        |=> error_flag && $stable(error_code))
    else $error("mask write disturbed a recorded error");

    chk_mask_reset: assert property (
        $past(srst) |-> mask == `CSPP_MASK_RST)
    else $error("mask reset value wrong");

    chk_rsv_zero: assert property (
        bus.rd && bus.addr == `CSPP_OFS_MASK
        |=> rd_data[`CSPP_RSV_MSB:`CSPP_RSV_LSB] == '0)
    else $error("reserved mask bits not zero");

    chk_state_live: assert property (
        bus.rd && bus.addr == `CSPP_OFS_RUN_STATE
        |=> rd_data[`CSPP_STATE_MSB:0] == $past(live_state))
    else $error("run state read not live");

    chk_state_off: assert property (
        !core_cond.active |=> run_state == CSPP_ST_OFF)
    else $error("inactive core not reported as off");

    chk_state_stall: assert property (
        core_cond.active && core_cond.stalled |=> run_state == CSPP_ST_STALL)
    else $error("stall not reported");

    chk_state_pause: assert property (
        core_cond.active && !core_cond.stalled && core_cond.paused
        |=> run_state == CSPP_ST_PAUSE)
    else $error("pause not reported");

    chk_state_sleep: assert property (
        core_cond.active && !core_cond.stalled && !core_cond.paused
        && core_cond.sleeping |=> run_state == CSPP_ST_SLEEP)
    else $error("sleep not reported");

    chk_state_run: assert property (
        core_cond.active && !core_cond.stalled && !core_cond.paused
        && !core_cond.sleeping |=> run_state == CSPP_ST_RUN)
    else $error("running core not reported");

    chk_irq_level: assert property (
        irq == |(irq_stat & irq_mask))
    else $error("interrupt output disagrees with status and mask");

    chk_code_captures: assert property (
        s_first_error |=> error_code == $past(reported))
    else $error("first error not captured in the code");

    chk_set_wins: assert property (
        clear_edge && any_report
        |=> error_flag && (error_code == $past(reported)))
    else $error("report in the clear cycle was lost");

    chk_irq_clear: assert property (
        wr_irq_stat && bus.wdata[`CSPP_EV_ERR] && !any_report
        |=> !irq_stat[`CSPP_EV_ERR])
    else $error("interrupt status bit not cleared by a one");

    chk_err_event: assert property (
        any_report |=> irq_stat[`CSPP_EV_ERR])
    else $error("error report did not raise interrupt status");

    chk_state_event: assert property (
        live_state != run_state |=> irq_stat[`CSPP_EV_STATE])
    else $error("run-state change did not raise interrupt status");

    chk_rd_idle: assert property (
        !bus.rd |=> rd_data == '0)
    else $error("read data not zero outside a read");

endmodule // cspp_core

`default_nettype wire

// *** verification/cspp_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

`include "cspp_defines.svh"

module tb
    import cspp_pkg::*;
;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic                   clk_sys;
    logic                   srst;
    cspp_bus_req_t          bus;
    logic [15:0]            rd_data;
    cspp_core_cond_t        core_cond;
    logic [11:0]            parity_err;
    logic                   error_flag;
    logic [11:0]            error_code;
    cspp_run_state_t        run_state;
    logic                   irq;
    int                     mismatches;
    int                     tests_run;
    int                     cycles = 0;
    logic                   rd_d = 1'b0;
    logic [15:0]            exp_q[$];
    string                  nm_q[$];
    logic [3:0]             cc_tab [8];
    logic [2:0]             cx_tab [8];
    logic [11:0]            m;
    logic [11:0]            p;

    cspp_core DUT (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .bus        (bus),
        .rd_data    (rd_data),
        .core_cond  (core_cond),
        .parity_err (parity_err),
        .error_flag (error_flag),
        .error_code (error_code),
        .run_state  (run_state),
        .irq        (irq)
    );

    // ----------------------------------------------------------------
    // clock, timeout, verdict
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            print_verdict();
        end
    end

    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ----------------------------------------------------------------
    // read data watcher: oldest note against data in the cycle after rd
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (rd_d) begin
            if (exp_q.size() == 0) begin
                check("unexpected read", rd_data, 16'hFFFF);
            end else begin
                check(nm_q.pop_front(), rd_data, exp_q.pop_front());
            end
        end else if (!srst) begin
            check("rd_data idle", rd_data, 16'h0000);
        end
        rd_d <= bus.rd;
    end

    // ----------------------------------------------------------------
    // bus and stimulus tasks
    // ----------------------------------------------------------------
    task automatic step(input cspp_bus_req_t r, input logic [11:0] pe);
        bus        <= r;
        parity_err <= pe;
        @(posedge clk_sys);
    endtask

    task automatic idle(input int n);
        repeat (n) step('0, 12'h000);
    endtask

    task automatic inj(input logic [11:0] pe);
        step('0, pe);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        step('{addr: a, wdata: d, wr: 1'b1, rd: 1'b0}, 12'h000);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [15:0] e, input string nm);
        exp_q.push_back(e);
        nm_q.push_back(nm);
        step('{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1}, 12'h000);
    endtask

    task automatic clr();
        wr(`CSPP_OFS_CLEAR, 16'h0001);
        wr(`CSPP_OFS_CLEAR, 16'h0000);
    endtask

    task automatic err_is(input logic f, input logic [11:0] c);
        check("error_flag", error_flag, f);
        check("error_code", error_code, c);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        cc_tab = '{4'b1000, 4'b1100, 4'b1010, 4'b1001, 4'b1111, 4'b1110, 4'b0111, 4'b0000};
        cx_tab = '{3'b001, 3'b010, 3'b011, 3'b100, 3'b100, 3'b010, 3'b000, 3'b000};
        mismatches = 0;
        tests_run  = 0;
        srst       = 1'b1;
        bus        = '0;
        core_cond  = '0;
        parity_err = 12'h000;
        void'($urandom(32'hD709));
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        idle(1);
        // reset values and unmapped space
        rd_chk(`CSPP_OFS_MASK, 16'h0003, "mask reset");
        rd_chk(`CSPP_OFS_CLEAR, 16'h0000, "clear reset");
        rd_chk(`CSPP_OFS_FLAG, 16'h0000, "flag reset");
        rd_chk(`CSPP_OFS_CODE, 16'h0000, "code reset");
        rd_chk(`CSPP_OFS_RUN_STATE, 16'h0000, "state after boot");
        rd_chk(`CSPP_OFS_IRQ_STAT, 16'h0000, "irq status reset");
        rd_chk(`CSPP_OFS_IRQ_MASK, 16'h0000, "irq mask reset");
        wr(16'hF400, 16'hFFFF);
        rd_chk(16'hF400, 16'h0000, "unmapped read");
        rd_chk(`CSPP_OFS_MASK, 16'h0003, "mask after unmapped write");
        wr(`CSPP_OFS_MASK, 16'hFFFF);
        rd_chk(`CSPP_OFS_MASK, 16'h0FFF, "mask reserved bits");
        // run state codes, read in the same cycle the condition changes
        for (int i = 0; i < 8; i++) begin
            core_cond <= cc_tab[i];
            rd_chk(`CSPP_OFS_RUN_STATE, {13'h0, cx_tab[i]}, "live run state");
            idle(1);
            check("run_state port", run_state, cx_tab[i]);
        end
        // interrupt: masked, unmasked, cleared
        idle(1);
        check("irq masked", irq, 1'b0);
        rd_chk(`CSPP_OFS_IRQ_STAT, 16'h0002, "irq status state change");
        wr(`CSPP_OFS_IRQ_MASK, 16'h0003);
        idle(2);
        check("irq unmasked", irq, 1'b1);
        wr(`CSPP_OFS_IRQ_STAT, 16'h0003);
        idle(2);
        check("irq cleared", irq, 1'b0);
        rd_chk(`CSPP_OFS_IRQ_STAT, 16'h0000, "irq status cleared");
        // per-source mask map: only source i unmasked, all sources fail
        for (int i = 0; i < 12; i++) begin
            wr(`CSPP_OFS_MASK, {4'h0, ~(12'h001 << i)});
            inj(12'hFFF);
            idle(1);
            err_is(1'b1, 12'h001 << i);
            rd_chk(`CSPP_OFS_CODE, {4'h0, 12'h001 << i}, "code map");
            if (i == 0) begin
                check("irq on report", irq, 1'b1);
                rd_chk(`CSPP_OFS_IRQ_STAT, 16'h0001, "irq status report");
                wr(`CSPP_OFS_IRQ_STAT, 16'h0001);
            end
            clr();
            idle(1);
            err_is(1'b0, 12'h000);
        end
        check("irq status sticky", irq, 1'b1);
        wr(`CSPP_OFS_IRQ_STAT, 16'h0001);
        idle(1);
        check("irq after w1c", irq, 1'b0);
        // random masks and errors
        for (int i = 0; i < 8; i++) begin
            m = 12'($urandom());
            p = 12'($urandom());
            wr(`CSPP_OFS_MASK, {4'h0, m});
            inj(p);
            idle(1);
            err_is((p & ~m) != 12'h000, p & ~m);
            clr();
        end
        // sticky flag, first error, mask set afterwards, level of clear
        wr(`CSPP_OFS_MASK, 16'h0000);
        inj(12'h010);
        inj(12'h020);
        idle(3);
        err_is(1'b1, 12'h010);
        rd_chk(`CSPP_OFS_FLAG, 16'h0001, "flag sticky");
        wr(`CSPP_OFS_MASK, 16'h0FFF);
        idle(2);
        err_is(1'b1, 12'h010);
        wr(`CSPP_OFS_CLEAR, 16'h0001);
        idle(2);
        err_is(1'b0, 12'h000);
        rd_chk(`CSPP_OFS_CLEAR, 16'h0001, "clear readback");
        inj(12'h040);
        idle(1);
        err_is(1'b0, 12'h000);
        wr(`CSPP_OFS_MASK, 16'h0000);
        inj(12'h040);
        idle(4);
        err_is(1'b1, 12'h040);
        wr(`CSPP_OFS_CLEAR, 16'h0000);
        idle(2);
        err_is(1'b1, 12'h040);
        wr(`CSPP_OFS_CLEAR, 16'h0001);
        wr(`CSPP_OFS_CLEAR, 16'h0000);
        idle(1);
        err_is(1'b0, 12'h000);
        inj(12'h100);
        idle(1);
        err_is(1'b1, 12'h100);
        wr(`CSPP_OFS_CLEAR, 16'h0001);
        inj(12'h080);
        idle(1);
        err_is(1'b1, 12'h080);
        wr(`CSPP_OFS_CLEAR, 16'h0000);
        idle(3);
        check("reads left", 16'(exp_q.size()), 16'h0000);
        print_verdict();
    end

endmodule // tb

`default_nettype wire
